// ### hw/mis_sequencer.sv
// instruction sequencer and execution timing of the 8-bit core
`default_nettype none
`include "mis_consts.svh"
module mis_sequencer
   import mis_pkg::*;
(
   input  wire logic        CLK_I,
   input  wire logic        SYS_RST_I,
   input  wire logic        CLK_OPT_I,
   input  wire logic        WAKE_I,
   input  wire logic        INT_ACK_I,
   input  wire logic [15:0] PROG_DATA_I,
   input  wire logic [7:0]  DMEM_RDATA_I,
   output logic [11:0]      PROG_ADDR_O,
   output logic [7:0]       DMEM_ADDR_O,
   output logic [7:0]       DMEM_WDATA_O,
   output logic             DMEM_WE_O,
   output logic [7:0]       ACC_O,
   output logic             ZERO_O,
   output logic             CARRY_O,
   output logic [7:0]       TBLH_O,
   output logic             GIE_O,
   output logic             PDN_O,
   output logic             FREQ_SEL_O,
   output logic [1:0]       PHASE_O,
   output logic             INSTR_DONE_O
);
   logic [1:0]    phase;
   logic          ph_last;
   mis_state_type state_r;
   mis_state_type state_nxt;
   logic [11:0]   pc_r;
   logic [11:0]   pc_nxt;
   logic [11:0]   prog_addr_r;
   logic [15:0]   ir_r;
   logic [7:0]    dmem_addr_r;
   logic [7:0]    mdat_r;
   logic [7:0]    wdata_r;
   logic          we_r;
   logic [7:0]    acc_r;
   logic [7:0]    acc_nxt;
   logic          zero_r;
   logic          carry_r;
   logic [7:0]    tblh_r;
   logic [7:0]    tlow_r;
   logic          gie_r;
   logic          pdn_r;
   logic          opt_r;
   logic          opt_held_r;
   logic [11:0]   stack_r [0:`MIS_STACK_DEPTH-1];
   logic [2:0]    sp_r;

   logic [3:0]    cls;
   logic [3:0]    sub;
   logic [7:0]    opnd;
   logic          exec;
   logic          acc_we;
   logic          mem_wr;
   logic [7:0]    mem_wdat;
   logic          flag_we;
   logic          nonseq;
   logic          push;
   logic          pop;
   logic          halt;
   logic          set_gie;
   logic          tbl_go;
   logic          skip;
   logic [3:0]    alu_op;
   logic [7:0]    alu_b;
   logic [7:0]    alu_res;
   logic          alu_cout;
   logic          alu_c_upd;
   logic          alu_z_upd;

   mis_phase_gen u_phase (
      .clk_i   (CLK_I),
      .rst_i   (SYS_RST_I),
      .phase_o (phase),
      .last_o  (ph_last)
   );

   mis_alu u_alu (
      .op_i    (alu_op),
      .a_i     (acc_r),
      .b_i     (alu_b),
      .cin_i   (carry_r),
      .res_o   (alu_res),
      .cout_o  (alu_cout),
      .c_upd_o (alu_c_upd),
      .z_upd_o (alu_z_upd)
   );

   assign cls  = ir_r[15:12];
   assign sub  = ir_r[11:8];
   assign opnd = ir_r[7:0];
   // every instruction retires on the last phase of its first cycle
   assign exec = ph_last && (state_r == S_EXEC); // RL1 RL2

   always_comb begin
      pc_nxt   = pc_r + 12'h001;
      acc_nxt  = acc_r;
      acc_we   = 1'b0;
      mem_wr   = 1'b0;
      mem_wdat = mdat_r;
      flag_we  = 1'b0;
      nonseq   = 1'b0;
      push     = 1'b0;
      pop      = 1'b0;
      halt     = 1'b0;
      set_gie  = 1'b0;
      tbl_go   = 1'b0;
      skip     = 1'b0;
      alu_op   = sub;
      alu_b    = mdat_r;
      unique case (cls)
         `MIS_CLS_MISC: begin
            if (sub == `MIS_MISC_HALT) begin
               halt = 1'b1; // RL15
            end else if (sub == `MIS_MISC_SUBEXIT ||
                         sub == `MIS_MISC_INTEXIT) begin
               pop     = 1'b1;
               pc_nxt  = stack_r[sp_r - 3'h1]; // RL12
               nonseq  = 1'b1;
               set_gie = (sub == `MIS_MISC_INTEXIT); // RL18
            end
         end
         `MIS_CLS_MOVAM: begin
            acc_nxt = mdat_r; // RL13
            acc_we  = 1'b1;
         end
         `MIS_CLS_MOVMA: begin
            mem_wdat = acc_r; // RL13
            mem_wr   = 1'b1;
         end
         `MIS_CLS_MOVAX: begin
            acc_nxt = opnd; // RL13
            acc_we  = 1'b1;
         end
         `MIS_CLS_ALUA: begin
            acc_nxt = alu_res;
            acc_we  = 1'b1;
            flag_we = 1'b1;
         end
         `MIS_CLS_ALUX: begin
            alu_b   = opnd;
            acc_nxt = alu_res;
            acc_we  = 1'b1;
            flag_we = 1'b1;
         end
         `MIS_CLS_ALUM: begin
            mem_wdat = alu_res;
            mem_wr   = 1'b1;
            flag_we  = 1'b1;
         end
         `MIS_CLS_BCLR: begin
            mem_wdat = mis_put_bit(mdat_r, sub[2:0], 1'b0); // RL11
            mem_wr   = 1'b1;
         end
         `MIS_CLS_BSET: begin
            mem_wdat = mis_put_bit(mdat_r, sub[2:0], 1'b1); // RL11
            mem_wr   = 1'b1;
         end
         `MIS_CLS_SKIP: begin
            unique case (sub)
               `MIS_SKIP_SZ:   skip = (mdat_r == 8'h00);
               `MIS_SKIP_SNZ:  skip = (mdat_r != 8'h00);
               `MIS_SKIP_SZB:  skip = !mdat_r[opnd[2:0]];
               `MIS_SKIP_SNZB: skip = mdat_r[opnd[2:0]];
               `MIS_SKIP_SIZ: begin
                  mem_wdat = mdat_r + 8'h01; // RL8
                  mem_wr   = 1'b1;
                  skip     = (mem_wdat == 8'h00);
               end
               `MIS_SKIP_SDZ: begin
                  mem_wdat = mdat_r - 8'h01; // RL8
                  mem_wr   = 1'b1;
                  skip     = (mem_wdat == 8'h00);
               end
               default: skip = 1'b0;
            endcase
            if (skip) begin
               pc_nxt = pc_r + 12'h002; // RL5
               nonseq = 1'b1; // RL4
            end
         end
         `MIS_CLS_JUMP: begin
            pc_nxt = ir_r[11:0]; // RL12
            nonseq = 1'b1;
         end
         `MIS_CLS_CALL: begin
            push   = 1'b1;
            pc_nxt = ir_r[11:0];
            nonseq = 1'b1;
         end
         `MIS_CLS_TABRD: begin
            tbl_go = 1'b1; // RL14
         end
         default: begin
            nonseq = 1'b0;
         end
      endcase
      // a write landing on the low program counter byte is a jump
      if (mem_wr && opnd == `MIS_PC_LOW_ADDR) begin
         pc_nxt = {pc_r[11:8], mem_wdat}; // RL3
         nonseq = 1'b1; // RL3
      end
   end

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         S_EXEC: begin
            if (halt) begin
               state_nxt = S_HALT;
            end else if (tbl_go) begin
               state_nxt = S_TABLE; // RL1
            end else if (nonseq) begin
               state_nxt = S_FLUSH; // RL19
            end
         end
         S_FLUSH: state_nxt = S_EXEC;
         S_TABLE: state_nxt = S_EXEC;
         S_HALT: begin
            if (WAKE_I) begin
               state_nxt = S_FLUSH;
            end
         end
      endcase
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         state_r <= S_EXEC;
      end else if (ph_last) begin
         state_r <= state_nxt; // RL2
      end
   end

   // fetch address goes out on phase 0, the word is taken on phase 1
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         prog_addr_r <= `MIS_PC_RESET;
      end else if (phase == `MIS_PHASE_FETCH) begin
         if (state_r == S_TABLE) begin
            prog_addr_r <= {`MIS_TBL_PAGE, acc_r}; // RL14
         end else begin
            prog_addr_r <= pc_r;
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         ir_r        <= 16'h0000;
         dmem_addr_r <= 8'h00;
         tlow_r      <= 8'h00;
         tblh_r      <= 8'h00;
      end else if (phase == `MIS_PHASE_DECODE) begin
         if (state_r == S_EXEC) begin
            ir_r        <= PROG_DATA_I;
            dmem_addr_r <= PROG_DATA_I[7:0];
         end else if (state_r == S_TABLE) begin
            tlow_r <= PROG_DATA_I[7:0]; // RL14
            tblh_r <= PROG_DATA_I[15:8]; // RL14
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         mdat_r <= 8'h00;
      end else if (phase == `MIS_PHASE_READ) begin
         mdat_r <= DMEM_RDATA_I; // RL11
      end
   end

   // write strobe lasts one clock, in phase 0 of the following cycle
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         we_r    <= 1'b0;
         wdata_r <= 8'h00;
      end else if (exec && mem_wr) begin
         we_r    <= 1'b1;
         wdata_r <= mem_wdat; // RL11
      end else if (ph_last && state_r == S_TABLE) begin
         we_r    <= 1'b1;
         wdata_r <= tlow_r; // RL14
      end else begin
         we_r <= 1'b0;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         pc_r <= `MIS_PC_RESET;
      end else if (exec) begin
         pc_r <= pc_nxt; // RL5 RL12
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         acc_r <= 8'h00;
      end else if (exec && acc_we) begin
         acc_r <= acc_nxt; // RL13
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         zero_r  <= 1'b0;
         carry_r <= 1'b0;
      end else if (exec && flag_we) begin
         if (alu_z_upd) begin
            zero_r <= (alu_res == 8'h00); // RL6
         end
         if (alu_c_upd) begin
            carry_r <= alu_cout; // RL7 RL10
         end
      end
   end

   // return address stack; deeper nesting than the depth wraps silently
   always_ff @(posedge CLK_I) begin
      if (exec && push) begin
         stack_r[sp_r] <= pc_r + 12'h001; // RL12
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         sp_r <= 3'h0;
      end else if (exec && push) begin
         sp_r <= sp_r + 3'h1;
      end else if (exec && pop) begin
         sp_r <= sp_r - 3'h1;
      end
   end

   // setting by interrupt exit wins over a same-cycle acknowledge
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         gie_r <= `MIS_GIE_RESET;
      end else if (exec && set_gie) begin
         gie_r <= 1'b1; // RL18
      end else if (INT_ACK_I) begin
         gie_r <= 1'b0;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         pdn_r <= 1'b0;
      end else if (exec && halt) begin
         pdn_r <= 1'b1; // RL15
      end else if (ph_last && state_r == S_HALT && WAKE_I) begin
         pdn_r <= 1'b0;
      end
   end

   // option strap is caught once after reset; no instruction reaches it
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         opt_held_r <= 1'b0;
         opt_r      <= `MIS_FREQ_12MHZ;
      end else if (!opt_held_r) begin
         opt_held_r <= 1'b1; // RL17
         opt_r      <= CLK_OPT_I; // RL16
      end
   end

   assign PROG_ADDR_O  = prog_addr_r;
   assign DMEM_ADDR_O  = dmem_addr_r;
   assign DMEM_WDATA_O = wdata_r;
   assign DMEM_WE_O    = we_r;
   assign ACC_O        = acc_r;
   assign ZERO_O       = zero_r;
   assign CARRY_O      = carry_r;
   assign TBLH_O       = tblh_r;
   assign GIE_O        = gie_r;
   assign PDN_O        = pdn_r;
   assign FREQ_SEL_O   = opt_r;
   assign PHASE_O      = phase;
   assign INSTR_DONE_O = exec;
endmodule : mis_sequencer
`default_nettype wire

// ### hw/mis_consts.svh
// constants for the mcu instruction sequencer
// Behaviour
// RL1: plain instructions take one cycle; branch, call, table read take two
// RL2: one instruction cycle is exactly four system clock cycles
// RL3: writing the program counter low byte jumps and costs one extra cycle
// RL4: skip test costs one cycle, plus one more when a skip happens
// RL5: skip tests continue with next instruction or skip exactly one
// RL6: AND, OR, XOR and invert set zero flag on zero result
// RL7: add flags carry above 255, subtract flags borrow below 0
// RL8: increment and decrement change the operand by exactly one
// RL9: rotates move one bit, the leaving bit re-enters at other end
// RL10: rotate via carry moves out-bit to carry, old carry into gap
// RL11: bit set and clear read, modify one bit, write back
// RL12: subroutine exit resumes after the call; plain jump saves nothing
// RL13: moves go register to accumulator, accumulator to register, immediate
// RL14: table read fetches program memory data into the data path
// RL15: halt instruction enters power-down state
// RL16: clock option is only 12MHz or 6MHz, fixed at programming
// RL17: programmed options cannot be changed by any instruction
// RL18: interrupt exit returns, sets global enable; subroutine exit does not
// RL19: four phases per cycle, restart at reset, extra fetch on jumps
`ifndef MIS_CONSTS_SVH
`define MIS_CONSTS_SVH

`define MIS_PHASES        3'h4
`define MIS_PHASE_FETCH   2'h0
`define MIS_PHASE_DECODE  2'h1
`define MIS_PHASE_READ    2'h2
`define MIS_PHASE_EXEC    2'h3

`define MIS_PC_RESET      12'h000
`define MIS_TBL_PAGE      4'hF
`define MIS_PC_LOW_ADDR   8'h06
`define MIS_STACK_DEPTH   8

`define MIS_CLS_MISC      4'h0
`define MIS_CLS_MOVAM     4'h1
`define MIS_CLS_MOVMA     4'h2
`define MIS_CLS_MOVAX     4'h3
`define MIS_CLS_ALUA      4'h4
`define MIS_CLS_ALUX      4'h5
`define MIS_CLS_BCLR      4'h6
`define MIS_CLS_BSET      4'h7
`define MIS_CLS_SKIP      4'h8
`define MIS_CLS_JUMP      4'h9
`define MIS_CLS_CALL      4'hA
`define MIS_CLS_TABRD     4'hB
`define MIS_CLS_ALUM      4'hC

`define MIS_MISC_NOP      4'h0
`define MIS_MISC_HALT     4'h1
`define MIS_MISC_SUBEXIT  4'h2
`define MIS_MISC_INTEXIT  4'h3

`define MIS_SKIP_SZ       4'h0
`define MIS_SKIP_SNZ      4'h1
`define MIS_SKIP_SZB      4'h2
`define MIS_SKIP_SNZB     4'h3
`define MIS_SKIP_SIZ      4'h4
`define MIS_SKIP_SDZ      4'h5

`define MIS_ALU_ADD       4'h0
`define MIS_ALU_ADC       4'h1
`define MIS_ALU_SUB       4'h2
`define MIS_ALU_SBC       4'h3
`define MIS_ALU_AND       4'h4
`define MIS_ALU_OR        4'h5
`define MIS_ALU_XOR       4'h6
`define MIS_ALU_INV       4'h7
`define MIS_ALU_INC       4'h8
`define MIS_ALU_DEC       4'h9
`define MIS_ALU_RR        4'hA
`define MIS_ALU_RL        4'hB
`define MIS_ALU_RR_VC     4'hC
`define MIS_ALU_RL_VC     4'hD

`define MIS_FREQ_12MHZ    1'b1
`define MIS_FREQ_6MHZ     1'b0
`define MIS_GIE_RESET     1'b0

`endif

// ### hw/mis_pkg.sv
// types and helpers of the mcu instruction sequencer
`default_nettype none
package mis_pkg;

   typedef enum logic [1:0] {
      S_EXEC,
      S_FLUSH,
      S_TABLE,
      S_HALT
   } mis_state_type;

   // replace one bit of a byte, the other seven stay as read
   function automatic logic [7:0] mis_put_bit(input logic [7:0] d,
                                              input logic [2:0] idx,
                                              input logic       val);
      logic [7:0] r;
      r      = d;
      r[idx] = val;
      return r;
   endfunction : mis_put_bit

endpackage : mis_pkg
`default_nettype wire

// ### hw/mis_phase_gen.sv
// four-phase generator for the instruction cycle
`default_nettype none
`include "mis_consts.svh"
module mis_phase_gen
   import mis_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   output logic [1:0]      phase_o,
   output logic            last_o
);
   logic [1:0] phase_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_r <= `MIS_PHASE_FETCH; // RL19
      end else begin
         phase_r <= phase_r + 2'h1; // RL2
      end
   end

   assign phase_o = phase_r;
   assign last_o  = (phase_r == `MIS_PHASE_EXEC);
endmodule : mis_phase_gen
`default_nettype wire

// ### hw/mis_alu.sv
// 8-bit arithmetic, logic and rotate unit
`default_nettype none
`include "mis_consts.svh"
module mis_alu
   import mis_pkg::*;
(
   input  wire logic [3:0] op_i,
   input  wire logic [7:0] a_i,
   input  wire logic [7:0] b_i,
   input  wire logic       cin_i,
   output logic [7:0]      res_o,
   output logic            cout_o,
   output logic            c_upd_o,
   output logic            z_upd_o
);
   logic [8:0] sum;

   always_comb begin
      sum     = 9'h000;
      res_o   = b_i;
      cout_o  = cin_i;
      c_upd_o = 1'b0;
      z_upd_o = 1'b1;
      unique case (op_i)
         `MIS_ALU_ADD: begin
            sum     = {1'b0, a_i} + {1'b0, b_i};
            res_o   = sum[7:0];
            cout_o  = sum[8]; // RL7
            c_upd_o = 1'b1;
         end
         `MIS_ALU_ADC: begin
            sum     = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin_i};
            res_o   = sum[7:0];
            cout_o  = sum[8]; // RL7
            c_upd_o = 1'b1;
         end
         `MIS_ALU_SUB: begin
            sum     = {1'b0, a_i} - {1'b0, b_i};
            res_o   = sum[7:0];
            cout_o  = sum[8]; // RL7
            c_upd_o = 1'b1;
         end
         `MIS_ALU_SBC: begin
            // carry holds the pending borrow here
            sum     = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin_i};
            res_o   = sum[7:0];
            cout_o  = sum[8]; // RL7
            c_upd_o = 1'b1;
         end
         `MIS_ALU_AND: res_o = a_i & b_i; // RL6
         `MIS_ALU_OR:  res_o = a_i | b_i; // RL6
         `MIS_ALU_XOR: res_o = a_i ^ b_i; // RL6
         `MIS_ALU_INV: res_o = ~b_i; // RL6
         `MIS_ALU_INC: res_o = b_i + 8'h01; // RL8
         `MIS_ALU_DEC: res_o = b_i - 8'h01; // RL8
         `MIS_ALU_RR: begin
            res_o   = {b_i[0], b_i[7:1]}; // RL9
            z_upd_o = 1'b0;
         end
         `MIS_ALU_RL: begin
            res_o   = {b_i[6:0], b_i[7]}; // RL9
            z_upd_o = 1'b0;
         end
         `MIS_ALU_RR_VC: begin
            res_o   = {cin_i, b_i[7:1]}; // RL10
            cout_o  = b_i[0];
            c_upd_o = 1'b1;
            z_upd_o = 1'b0;
         end
         `MIS_ALU_RL_VC: begin
            res_o   = {b_i[6:0], cin_i}; // RL10
            cout_o  = b_i[7];
            c_upd_o = 1'b1;
            z_upd_o = 1'b0;
         end
         default: begin
            z_upd_o = 1'b0;
         end
      endcase
   end
endmodule : mis_alu
`default_nettype wire

// ### testbench/mis_mem_model.sv
// program and data memory standing beside the sequencer
`default_nettype none
module mis_mem_model (
   input  wire logic        clk_i,
   input  wire logic [11:0] prog_addr_i,
   output logic [15:0]      prog_data_o,
   input  wire logic [7:0]  dmem_addr_i,
   output logic [7:0]       dmem_rdata_o,
   input  wire logic [7:0]  dmem_wdata_i,
   input  wire logic        dmem_we_i
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] rom [0:4095];
   logic [7:0]  ram [0:255];
   // combinational read of the registered addresses
   assign prog_data_o  = rom[prog_addr_i];
   assign dmem_rdata_o = ram[dmem_addr_i];
   // write lands at the edge closing c0, while the address still stands
   always @(posedge clk_i) begin
      if (dmem_we_i === 1'b1) begin
         ram[dmem_addr_i] <= dmem_wdata_i;
      end
   end
   // empty program words read as no-op, unlike a blank part
   task automatic clear();
      for (int i = 0; i < 4096; i++) begin
         rom[i] = 16'h0000;
      end
      for (int i = 0; i < 256; i++) begin
         ram[i] = 8'h00;
      end
   endtask : clear
endmodule : mis_mem_model
`default_nettype wire

// ### testbench/mis_sequencer_properties.sv
// port assertions for the instruction sequencer
`default_nettype none
module mis_sequencer_checker (
   input wire logic       CLK_I,
   input wire logic       SYS_RST_I,
   input wire logic       CLK_OPT_I,
   input wire logic       WAKE_I,
   input wire logic       INT_ACK_I,
   input wire logic       DMEM_WE_O,
   input wire logic       GIE_O,
   input wire logic       PDN_O,
   input wire logic       FREQ_SEL_O,
   input wire logic [1:0] PHASE_O,
   input wire logic       INSTR_DONE_O
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (SYS_RST_I);

   a_done_spacing:
      assert property (INSTR_DONE_O |=> !INSTR_DONE_O [*3])
      else $error("instruction done closer than four clocks");
   a_done_phase:
      assert property (INSTR_DONE_O |-> PHASE_O == 2'h3)
      else $error("instruction done outside the last phase");
   a_phase_step:
      assert property (!$past(SYS_RST_I) && !$past(SYS_RST_I, 2)
         |-> PHASE_O == $past(PHASE_O) + 2'h1)
      else $error("phase did not advance by one");
   a_write_pulse:
      assert property (DMEM_WE_O |-> PHASE_O == 2'h0 ##1 !DMEM_WE_O)
      else $error("data write not a single c0 pulse");
   a_freq_take:
      assert property ($fell(SYS_RST_I) |=> FREQ_SEL_O == $past(CLK_OPT_I))
      else $error("clock option not captured after reset");
   a_freq_fixed:
      assert property (!$past(SYS_RST_I) && !$past(SYS_RST_I, 2)
         |-> $stable(FREQ_SEL_O))
      else $error("clock option changed while running");
   a_halt_quiet:
      assert property (PDN_O |-> !INSTR_DONE_O)
      else $error("instruction retired in power-down");
   a_halt_holds:
      assert property (PDN_O && !(WAKE_I && PHASE_O == 2'h3) |=> PDN_O)
      else $error("power-down left without wake");
   a_ack_clears:
      assert property (INT_ACK_I && !INSTR_DONE_O |=> !GIE_O)
      else $error("interrupt enable not cleared by acknowledge");
endmodule : mis_sequencer_checker

bind mis_sequencer mis_sequencer_checker u_chk (
   .CLK_I        (CLK_I),
   .SYS_RST_I    (SYS_RST_I),
   .CLK_OPT_I    (CLK_OPT_I),
   .WAKE_I       (WAKE_I),
   .INT_ACK_I    (INT_ACK_I),
   .DMEM_WE_O    (DMEM_WE_O),
   .GIE_O        (GIE_O),
   .PDN_O        (PDN_O),
   .FREQ_SEL_O   (FREQ_SEL_O),
   .PHASE_O      (PHASE_O),
   .INSTR_DONE_O (INSTR_DONE_O)
);
`default_nettype wire

// ### testbench/mis_sequencer_tb_top.sv
// self-checking bench for the instruction sequencer
`default_nettype none
module mis_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk, rst, clk_opt, wake, int_ack;
   logic [15:0] prog_data;
   logic [11:0] prog_addr;
   logic [7:0]  dmem_rdata, dmem_addr, dmem_wdata, acc, tblh;
   logic        dmem_we, zero, carry, gie, pdn, freq_sel, done;
   logic [1:0]  phase;
   int          compares = 0;
   int          miscompares = 0;

   mis_sequencer dut (.CLK_I(clk), .SYS_RST_I(rst), .CLK_OPT_I(clk_opt),
      .WAKE_I(wake), .INT_ACK_I(int_ack), .PROG_DATA_I(prog_data),
      .DMEM_RDATA_I(dmem_rdata), .PROG_ADDR_O(prog_addr),
      .DMEM_ADDR_O(dmem_addr), .DMEM_WDATA_O(dmem_wdata),
      .DMEM_WE_O(dmem_we), .ACC_O(acc), .ZERO_O(zero), .CARRY_O(carry),
      .TBLH_O(tblh), .GIE_O(gie), .PDN_O(pdn), .FREQ_SEL_O(freq_sel),
      .PHASE_O(phase), .INSTR_DONE_O(done));
   mis_mem_model mem (.clk_i(clk), .prog_addr_i(prog_addr),
      .prog_data_o(prog_data), .dmem_addr_i(dmem_addr),
      .dmem_rdata_o(dmem_rdata), .dmem_wdata_i(dmem_wdata),
      .dmem_we_i(dmem_we));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic give_verdict();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : give_verdict

   task automatic check(input string nm, input logic [15:0] e, g);
      compares++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         miscompares++;
      end
   endtask : check

   // word is class, sub-code, operand
   task automatic ld(input logic [11:0] a, input logic [3:0] c, s,
                     input logic [7:0] o);
      mem.rom[a] = {c, s, o};
   endtask : ld

   task automatic do_reset(input logic opt);
      @(posedge clk);
      rst     <= 1'b1;
      clk_opt <= opt;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
   endtask : do_reset

   // waits for the next retire; gap is clocks since the last one
   task automatic step(input int gap);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (done !== 1'b1 && n < 100);
      if (done !== 1'b1) begin
         $display("ERROR done expected 1 seen %b", done);
         miscompares++;
         give_verdict();
      end else begin
         if (gap > 0) check("gap", 16'(gap), 16'(n + 1));
         @(negedge clk);
      end
   endtask : step

   task automatic t_halt();
      mem.clear();
      ld(12'h000, 4'h0, 4'h1, 8'h00);
      ld(12'h001, 4'h3, 4'h0, 8'h77);
      do_reset(1'b0);
      @(negedge clk);
      check("gie", 16'h0, 16'(gie));
      repeat (2) @(negedge clk);
      check("freq", 16'h0, 16'(freq_sel));
      @(posedge clk);
      clk_opt <= 1'b1;
      step(0);
      repeat (8) @(negedge clk);
      check("pdn", 16'h1, 16'(pdn));
      check("acc", 16'h0, 16'(acc));
      @(posedge clk);
      wake <= 1'b1;
      step(0);
      check("acc", 16'h77, 16'(acc));
      check("freq", 16'h0, 16'(freq_sel));
      @(posedge clk);
      wake <= 1'b0;
   endtask : t_halt

   task automatic t_alu();
      mem.clear();
      ld(12'h000, 4'h3, 4'h0, 8'hF0);
      ld(12'h001, 4'h5, 4'h0, 8'h20);
      ld(12'h002, 4'h5, 4'h4, 8'h00);
      ld(12'h003, 4'h5, 4'h2, 8'h01);
      ld(12'h004, 4'h5, 4'h8, 8'h7F);
      ld(12'h005, 4'h5, 4'hC, 8'h80);
      ld(12'h006, 4'h5, 4'hB, 8'h81);
      ld(12'h007, 4'h5, 4'h6, 8'h03);
      ld(12'h008, 4'h5, 4'hD, 8'h80);
      ld(12'h009, 4'h5, 4'h3, 8'h00);
      do_reset(1'b1);
      step(0);
      check("acc", 16'hF0, 16'(acc));
      step(4);
      check("add", 16'h110, {7'h0, carry, acc});
      step(4);
      check("and", 16'h100, {7'h0, zero, acc});
      step(4);
      check("sub", 16'h1FF, {7'h0, carry, acc});
      step(4);
      check("inc", 16'h80, 16'(acc));
      step(4);
      check("rr_vc", 16'h0C0, {7'h0, carry, acc});
      step(4);
      check("rl", 16'h003, {7'h0, carry, acc});
      step(4);
      check("xor", 16'h100, {7'h0, zero, acc});
      step(4);
      check("rl_vc", 16'h100, {7'h0, carry, acc});
      step(4);
      check("sbc", 16'h1FF, {7'h0, carry, acc});
   endtask : t_alu

   task automatic t_mem();
      mem.clear();
      mem.ram[8'h10] = 8'h5A;
      mem.ram[8'h21] = 8'h07;
      mem.ram[8'h23] = 8'hFF;
      ld(12'h000, 4'h7, 4'h0, 8'h10);
      ld(12'h001, 4'h6, 4'h3, 8'h10);
      ld(12'h002, 4'hC, 4'h8, 8'h21);
      ld(12'h003, 4'h1, 4'h0, 8'h21);
      ld(12'h004, 4'h2, 4'h0, 8'h22);
      ld(12'h005, 4'h8, 4'h0, 8'h20);
      ld(12'h006, 4'h3, 4'h0, 8'h11);
      ld(12'h007, 4'h3, 4'h0, 8'h22);
      ld(12'h008, 4'h8, 4'h1, 8'h20);
      ld(12'h009, 4'h3, 4'h0, 8'h33);
      ld(12'h00A, 4'h8, 4'h4, 8'h23);
      ld(12'h00C, 4'h8, 4'h2, 8'h10);
      ld(12'h00D, 4'h3, 4'h0, 8'h44);
      do_reset(1'b1);
      step(0);
      step(4);
      step(4);
      step(4);
      check("acc", 16'h08, 16'(acc));
      step(4);
      step(4);
      step(8);
      check("skip", 16'h22, 16'(acc));
      step(4);
      step(4);
      check("noskip", 16'h33, 16'(acc));
      check("bits", 16'h53, 16'(mem.ram[8'h10]));
      check("inc", 16'h08, 16'(mem.ram[8'h21]));
      check("mov", 16'h08, 16'(mem.ram[8'h22]));
      step(4);
      step(8);
      step(4);
      check("siz", 16'h0044, {mem.ram[8'h23], acc});
   endtask : t_mem

   task automatic t_flow();
      mem.clear();
      ld(12'h000, 4'hA, 4'h0, 8'h10);
      ld(12'h001, 4'h3, 4'h0, 8'h44);
      ld(12'h002, 4'h9, 4'h0, 8'h20);
      ld(12'h003, 4'h3, 4'h0, 8'hEE);
      ld(12'h010, 4'h0, 4'h2, 8'h00);
      ld(12'h020, 4'h2, 4'h0, 8'h06);
      ld(12'h044, 4'h3, 4'h0, 8'h55);
      ld(12'h045, 4'hA, 4'h0, 8'h50);
      ld(12'h046, 4'h3, 4'h0, 8'h66);
      ld(12'h050, 4'h0, 4'h3, 8'h00);
      do_reset(1'b1);
      step(0);
      step(8);
      step(8);
      check("sub_exit", 16'h44, 16'(acc));
      step(4);
      step(8);
      step(8);
      check("pc_low", 16'h55, 16'(acc));
      check("gie", 16'h0, 16'(gie));
      step(4);
      step(8);
      step(8);
      check("int_exit", 16'h66, 16'(acc));
      check("gie", 16'h1, 16'(gie));
      @(posedge clk);
      int_ack <= 1'b1;
      @(posedge clk);
      int_ack <= 1'b0;
      @(negedge clk);
      check("ack", 16'h0, 16'(gie));
   endtask : t_flow

   task automatic t_table();
      mem.clear();
      mem.rom[12'hF05] = 16'hABCD;
      ld(12'h000, 4'h3, 4'h0, 8'h05);
      ld(12'h001, 4'hB, 4'h0, 8'h30);
      ld(12'h002, 4'h1, 4'h0, 8'h30);
      do_reset(1'b1);
      step(0);
      step(4);
      step(8);
      check("tbl", 16'hABCD, {tblh, acc});
   endtask : t_table

   initial begin
      rst     = 1'b1;
      clk_opt = 1'b1;
      wake    = 1'b0;
      int_ack = 1'b0;
      t_halt();
      t_alu();
      t_mem();
      t_flow();
      t_table();
      give_verdict();
   end
endmodule : mis_sequencer_tb_top
`default_nettype wire
